// >>> rtl/itb_map.svh
`ifndef ITB_MAP_SVH
`define ITB_MAP_SVH

// register byte offsets
`define ITB_OFF_PSC       8'h00
`define ITB_OFF_TB0       8'h04
`define ITB_OFF_TB1       8'h08
`define ITB_OFF_CTRL      8'h0c
`define ITB_OFF_FLAGS     8'h10
`define ITB_OFF_SRC       8'h14

// prescaler source codes
`define ITB_PSC_SYS       2'h0
`define ITB_PSC_SYS_DIV4  2'h1
`define ITB_PSC_DIV4_LAST 2'h3

// time base control fields
`define ITB_TB_ON_BIT     7
`define ITB_TB_PER_HI     2
`define ITB_TB_PER_LO     0
`define ITB_TB_MIN_PERIOD 16'h0100

// irq control fields
`define ITB_CTRL_GIE      0
`define ITB_CTRL_TBE_HI   2
`define ITB_CTRL_TBE_LO   1
`define ITB_CTRL_SLE      3
`define ITB_CTRL_GRE_HI   5
`define ITB_CTRL_GRE_LO   4

// flags and source fields
`define ITB_FLAGS_HI      4
`define ITB_SRC_EN_HI     5
`define ITB_SRC_FLAG_HI   13
`define ITB_SRC_FLAG_LO   8

// grouping of sources: timer A, timer P | low volt, eeprom, spi, serial module
`define ITB_GRP0_MASK     6'h03
`define ITB_GRP1_MASK     6'h3c

// vectors: tick0, tick1, serial link, group0, group1
`define ITB_NUM_VEC       5
`define ITB_VEC_BASE      12'h004
`define ITB_VEC_STEP      12'h004

`define ITB_HTRANS_NSEQ   1

`endif

// >>> rtl/itb_pkg.sv
`default_nettype none
package itb_pkg;

  typedef struct packed {
    logic [1:0]       pscSel;
    logic [1:0]       pscDiv;
    logic [1:0]       tbOn;
    logic [1:0][2:0]  tbPer;
    logic [1:0][14:0] tbCnt;
    logic             globalIrqEnable;
    logic [1:0]       tickIrqEnable;
    logic             serialLinkIrqEnable;
    logic [1:0]       groupIrqEnable;
    logic [1:0]       tickRequestFlag;
    logic             serialLinkIrqFlag;
    logic [1:0]       groupIrqFlag;
    logic [5:0]       srcIrqEnable;
    logic [5:0]       srcIrqFlag;
    logic             wrPend;
    logic [7:0]       addr;
    logic [31:0]      rdata;
    logic             svcValid;
    logic [2:0]       svcIdx;
    logic             wakeUp;
  } itb_state_t;

endpackage
`default_nettype wire

// >>> rtl/itb_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "itb_map.svh"

// Behaviour
// - time base overflow sets its tick flag
// - tick vectors need global and own enable
// - no service while return stack full
// - tick service clears flag and global enable
// - prescaler source: sys, sys/4, sub clock
// - period is 2^8 to 2^15 prescaled cycles
// - bit 7 switches time base, reset off
// - unimplemented bits read zero, ignore writes
// - six serial link conditions request interrupt
// - serial link service clears flag, global enable
// - serial module events set its flag
// - spi byte done sets its flag
// - low voltage sets grouped flag
// - eeprom write end sets grouped flag
// - timer compare A and P flags, enables
// - group service clears group flag and global enable only
// - any flag rising from a hardware event wakes the device; software writes that set flags do not
// - flags stay set until serviced or cleared
// - service pushes pc, loads vector; reti re-enables
module itb_irq_ctrl (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // core sequencer
  input  wire logic        stackFull,
  input  wire logic        retiPulse,
  output logic             svcValid,
  output logic [11:0]      svcVector,
  output logic             wakeUp,
  // interrupt sources
  input  wire logic        subClkTick,
  input  wire logic [5:0]  serialLinkEvt,
  input  wire logic        serialModuleEvt,
  input  wire logic        spiPortEvt,
  input  wire logic        lowVoltEvt,
  input  wire logic        eepromWriteEvt,
  input  wire logic        timerMatchA,
  input  wire logic        timerMatchP
);

  itb_pkg::itb_state_t st_q;
  itb_pkg::itb_state_t st_d;

  logic                 pscTick;
  logic [1:0]           tbOvf;
  logic [1:0][14:0]     tbCntNext;
  logic [5:0]           srcEvt;
  logic [5:0]           srcSet;
  logic [1:0]           grpSet;
  logic                 slSet;
  logic [4:0]           hwSet;
  logic [4:0]           flagsQ;
  logic [4:0]           enVec;
  logic [4:0]           pend;
  logic                 fire;
  logic [2:0]           fireIdx;
  logic                 accept;

  assign srcEvt = {serialModuleEvt, spiPortEvt, eepromWriteEvt, lowVoltEvt,
                   timerMatchP, timerMatchA};
  assign accept = hsel & htrans[`ITB_HTRANS_NSEQ] & hready;

  // prescaled clock enable
  always_comb begin
    case (st_q.pscSel)
      `ITB_PSC_SYS:      pscTick = 1'b1;
      `ITB_PSC_SYS_DIV4: pscTick = (st_q.pscDiv == `ITB_PSC_DIV4_LAST);
      default:           pscTick = subClkTick;
    endcase
  end

  // per time base divider
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tb
      logic [14:0] lastCnt;
      assign lastCnt = 15'((`ITB_TB_MIN_PERIOD << st_q.tbPer[gi]) - 16'h0001);
      assign tbOvf[gi] = st_q.tbOn[gi] & pscTick & (st_q.tbCnt[gi] >= lastCnt);
      always_comb begin
        if (!st_q.tbOn[gi] || tbOvf[gi]) begin
          tbCntNext[gi] = 15'h0000;
        end else if (pscTick) begin
          tbCntNext[gi] = st_q.tbCnt[gi] + 15'h0001;
        end else begin
          tbCntNext[gi] = st_q.tbCnt[gi];
        end
      end
    end
  endgenerate

  // hardware set events
  assign srcSet = srcEvt;
  assign grpSet[0] = |(srcSet & st_q.srcIrqEnable & `ITB_GRP0_MASK);
  assign grpSet[1] = |(srcSet & st_q.srcIrqEnable & `ITB_GRP1_MASK);
  assign slSet = |serialLinkEvt;
  assign hwSet = {grpSet, slSet, tbOvf};

  // arbitration
  assign flagsQ = {st_q.groupIrqFlag, st_q.serialLinkIrqFlag, st_q.tickRequestFlag};
  assign enVec = {st_q.groupIrqEnable, st_q.serialLinkIrqEnable, st_q.tickIrqEnable};
  assign pend = flagsQ & enVec & {`ITB_NUM_VEC{st_q.globalIrqEnable}};
  assign fire = (|pend) & ~stackFull;

  always_comb begin
    fireIdx = 3'h0;
    for (int i = `ITB_NUM_VEC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        fireIdx = 3'(i);
      end
    end
  end

  function automatic logic [31:0] readMux(input itb_pkg::itb_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `ITB_OFF_PSC:   r[1:0] = s.pscSel;
      `ITB_OFF_TB0: begin
        r[`ITB_TB_ON_BIT] = s.tbOn[0];
        r[`ITB_TB_PER_HI:`ITB_TB_PER_LO] = s.tbPer[0];
      end
      `ITB_OFF_TB1: begin
        r[`ITB_TB_ON_BIT] = s.tbOn[1];
        r[`ITB_TB_PER_HI:`ITB_TB_PER_LO] = s.tbPer[1];
      end
      `ITB_OFF_CTRL: begin
        r[`ITB_CTRL_GIE] = s.globalIrqEnable;
        r[`ITB_CTRL_TBE_HI:`ITB_CTRL_TBE_LO] = s.tickIrqEnable;
        r[`ITB_CTRL_SLE] = s.serialLinkIrqEnable;
        r[`ITB_CTRL_GRE_HI:`ITB_CTRL_GRE_LO] = s.groupIrqEnable;
      end
      `ITB_OFF_FLAGS: r[`ITB_FLAGS_HI:0] = {s.groupIrqFlag, s.serialLinkIrqFlag,
                                            s.tickRequestFlag};
      `ITB_OFF_SRC: begin
        r[`ITB_SRC_EN_HI:0] = s.srcIrqEnable;
        r[`ITB_SRC_FLAG_HI:`ITB_SRC_FLAG_LO] = s.srcIrqFlag;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.pscDiv = st_q.pscDiv + 2'h1;
    st_d.tbCnt = tbCntNext;
    // software write in data phase
    if (st_q.wrPend) begin
      case (st_q.addr)
        `ITB_OFF_PSC: st_d.pscSel = hwdata[1:0];
        `ITB_OFF_TB0: begin
          st_d.tbOn[0] = hwdata[`ITB_TB_ON_BIT];
          st_d.tbPer[0] = hwdata[`ITB_TB_PER_HI:`ITB_TB_PER_LO];
        end
        `ITB_OFF_TB1: begin
          st_d.tbOn[1] = hwdata[`ITB_TB_ON_BIT];
          st_d.tbPer[1] = hwdata[`ITB_TB_PER_HI:`ITB_TB_PER_LO];
        end
        `ITB_OFF_CTRL: begin
          st_d.globalIrqEnable = hwdata[`ITB_CTRL_GIE];
          st_d.tickIrqEnable = hwdata[`ITB_CTRL_TBE_HI:`ITB_CTRL_TBE_LO];
          st_d.serialLinkIrqEnable = hwdata[`ITB_CTRL_SLE];
          st_d.groupIrqEnable = hwdata[`ITB_CTRL_GRE_HI:`ITB_CTRL_GRE_LO];
        end
        `ITB_OFF_FLAGS: {st_d.groupIrqFlag, st_d.serialLinkIrqFlag,
                         st_d.tickRequestFlag} = hwdata[`ITB_FLAGS_HI:0];
        `ITB_OFF_SRC: begin
          st_d.srcIrqEnable = hwdata[`ITB_SRC_EN_HI:0];
          st_d.srcIrqFlag = hwdata[`ITB_SRC_FLAG_HI:`ITB_SRC_FLAG_LO];
        end
        default: st_d.rdata = st_q.rdata;
      endcase
    end
    if (retiPulse) begin
      st_d.globalIrqEnable = 1'b1;
    end
    // service: clear vector flag and global enable, never source flags
    if (fire) begin
      st_d.globalIrqEnable = 1'b0;
      case (fireIdx)
        3'h0:    st_d.tickRequestFlag[0] = 1'b0;
        3'h1:    st_d.tickRequestFlag[1] = 1'b0;
        3'h2:    st_d.serialLinkIrqFlag = 1'b0;
        3'h3:    st_d.groupIrqFlag[0] = 1'b0;
        3'h4:    st_d.groupIrqFlag[1] = 1'b0;
        default: st_d.groupIrqFlag = st_d.groupIrqFlag;
      endcase
    end
    st_d.svcValid = fire;
    st_d.svcIdx = fire ? fireIdx : st_q.svcIdx;
    // hardware sets win over any clear
    st_d.tickRequestFlag = st_d.tickRequestFlag | tbOvf;
    st_d.serialLinkIrqFlag = st_d.serialLinkIrqFlag | slSet;
    st_d.groupIrqFlag = st_d.groupIrqFlag | grpSet;
    st_d.srcIrqFlag = st_d.srcIrqFlag | srcSet;
    st_d.wakeUp = (|(hwSet & ~flagsQ)) | (|(srcSet & ~st_q.srcIrqFlag));
    // ahb address phase
    st_d.wrPend = accept & hwrite;
    st_d.addr = accept ? haddr[7:0] : st_q.addr;
    if (accept && !hwrite) begin
      st_d.rdata = readMux(st_d, haddr[7:0]);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;
  assign svcValid = st_q.svcValid;
  assign svcVector = 12'(`ITB_VEC_BASE + 12'(`ITB_VEC_STEP * st_q.svcIdx));
  assign wakeUp = st_q.wakeUp;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_svc_tick0;
    st_q.svcValid && (st_q.svcIdx == 3'h0);
  endsequence

  sequence s_svc_tick1;
    st_q.svcValid && (st_q.svcIdx == 3'h1);
  endsequence

  sequence s_svc_serial;
    st_q.svcValid && (st_q.svcIdx == 3'h2);
  endsequence

  sequence s_svc_grp0;
    st_q.svcValid && (st_q.svcIdx == 3'h3);
  endsequence

  sequence s_tick0_step;
    st_q.tbOn[0] && pscTick && !tbOvf[0];
  endsequence

  sequence s_grp_fire;
    fire && (fireIdx >= 3'h3) && !st_q.wrPend;
  endsequence

  chk_tick_flag_set: assert property (tbOvf[0] |=> st_q.tickRequestFlag[0])
    else $error("tick0 overflow did not set its flag");

  chk_tick_svc_enable: assert property (s_svc_tick0 |-> $past(st_q.globalIrqEnable)
                                        && $past(st_q.tickIrqEnable[0]))
    else $error("tick0 serviced without enables");

  chk_svc_stack_full: assert property (st_q.svcValid |-> !$past(stackFull))
    else $error("service while stack full");

  chk_svc_clear_gie: assert property (fire && !tbOvf[0] && fireIdx == 3'h0
                                      |=> !st_q.globalIrqEnable && !st_q.tickRequestFlag[0])
    else $error("tick0 service left flag or global enable set");

  chk_psc_div_four: assert property ((st_q.pscSel == `ITB_PSC_SYS_DIV4) && pscTick
                                     |-> st_q.pscDiv == `ITB_PSC_DIV4_LAST)
    else $error("divide by four prescale mistimed");

  chk_period_restart: assert property (tbOvf[1] |-> st_q.tbCnt[1] >= g_tb[1].lastCnt
                                       ##1 st_q.tbCnt[1] == 15'h0000)
    else $error("time base 1 overflow at wrong count");

  chk_off_holds_zero: assert property (!st_q.tbOn[0] |=> st_q.tbCnt[0] == 15'h0000)
    else $error("divider ran while off");

  chk_wake_on_rise: assert property ((|(srcSet & ~st_q.srcIrqFlag)) |=> wakeUp)
    else $error("flag rise did not wake");

  chk_grp_src_kept: assert property (s_grp_fire |=> ($past(st_q.srcIrqFlag)
                                     & ~st_q.srcIrqFlag) == 6'h00)
    else $error("group service cleared a source flag");

  chk_svc_lowest_first: assert property (fire |-> (pend & ((5'h01 << fireIdx) - 5'h01))
                                         == 5'h00)
    else $error("service not lowest pending vector");

  chk_svc_single: assert property (st_q.svcValid |=> !st_q.svcValid)
    else $error("service pulse malformed");

  chk_flag_sticky: assert property (st_q.serialLinkIrqFlag && !fire && !st_q.wrPend
                                    |=> st_q.serialLinkIrqFlag)
    else $error("serial link flag lost");

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero wait okay");

  chk_psc_sys_tick: assert property (st_q.pscSel == `ITB_PSC_SYS |-> pscTick)
    else $error("system clock prescale missed a tick");

  chk_psc_sub_tick: assert property (st_q.pscSel[1] |-> pscTick == subClkTick)
    else $error("sub clock prescale mismatch");

  chk_tick1_flag_set: assert property (tbOvf[1] |=> st_q.tickRequestFlag[1])
    else $error("tick1 overflow did not set its flag");

  chk_tick1_enables: assert property (s_svc_tick1 |-> $past(st_q.tickIrqEnable[1]))
    else $error("tick1 serviced without its enable");

  chk_gie_gates_fire: assert property (!st_q.globalIrqEnable |-> !fire)
    else $error("service taken with global enable off");

  chk_sl_enables: assert property (s_svc_serial |-> $past(st_q.serialLinkIrqEnable))
    else $error("serial link serviced without its enable");

  chk_grp0_enables: assert property (s_svc_grp0 |-> $past(st_q.groupIrqEnable[0]))
    else $error("group0 serviced without its enable");

  chk_svc_gie_low: assert property (st_q.svcValid |-> !st_q.globalIrqEnable)
    else $error("global enable still set after service");

  chk_tick1_clear: assert property (fire && fireIdx == 3'h1 && !tbOvf[1]
                                    |=> !st_q.tickRequestFlag[1])
    else $error("tick1 service left its flag set");

  chk_sl_clear: assert property (fire && fireIdx == 3'h2 && !slSet
                                 |=> !st_q.serialLinkIrqFlag)
    else $error("serial link service left its flag set");

  chk_grp_clear: assert property (fire && fireIdx == 3'h3 && !grpSet[0]
                                  |=> !st_q.groupIrqFlag[0])
    else $error("group0 service left its flag set");

  chk_sl_flag_set: assert property (slSet |=> st_q.serialLinkIrqFlag)
    else $error("serial link event did not set flag");

  chk_src_flag_set: assert property ((|srcSet)
                                     |=> (st_q.srcIrqFlag & $past(srcSet)) == $past(srcSet))
    else $error("source event did not set its flag");

  chk_grp1_flag_set: assert property (grpSet[1] |=> st_q.groupIrqFlag[1])
    else $error("group1 flag not set by enabled source");

  chk_grp0_flag_set: assert property (grpSet[0] |=> st_q.groupIrqFlag[0])
    else $error("group0 flag not set by enabled source");

  chk_reti_gie: assert property (retiPulse && !fire |=> st_q.globalIrqEnable)
    else $error("return did not restore global enable");

  chk_tick1_off_zero: assert property (!st_q.tbOn[1] |=> st_q.tbCnt[1] == 15'h0000)
    else $error("divider 1 ran while off");

  chk_tick0_step: assert property (s_tick0_step
                                   |=> st_q.tbCnt[0] == $past(st_q.tbCnt[0]) + 15'h0001)
    else $error("divider 0 did not step on tick");

  chk_tick0_hold: assert property (st_q.tbOn[0] && !pscTick |=> $stable(st_q.tbCnt[0]))
    else $error("divider 0 moved without tick");

  chk_wake_tick: assert property (tbOvf[0] && !st_q.tickRequestFlag[0] |=> wakeUp)
    else $error("tick0 flag rise did not wake");

endmodule
`default_nettype wire

// >>> verif/itb_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module itb_core_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // bench control
  input  wire logic       holdFull,
  input  wire logic [7:0] retDelay,
  // service handshake
  input  wire logic       svcValid,
  output logic            stackFull,
  output logic            retiPulse
);
  logic [7:0] cnt_q;
  assign stackFull = holdFull;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q     <= 8'h00;
      retiPulse <= 1'b0;
    end else begin
      retiPulse <= (cnt_q == 8'h01);
      if (svcValid) begin
        cnt_q <= retDelay;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/test_interrupt_sources_and_time_base.sv
`timescale 1ns/1ps
`default_nettype none
`include "itb_map.svh"
module test_interrupt_sources_and_time_base;
  logic        core_clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic        stackFull, retiPulse, svcValid, wakeUp, holdFull, subClkTick;
  logic [31:0] haddr, hwdata, hrdata, rd, d;
  logic [1:0]  htrans;
  logic [11:0] svcVector, tickVec;
  logic [5:0]  slEvt, srcEvt;
  logic [11:0] vecQ[$];
  int          nMismatch, nCompared, nWake, seed, subCnt, p;
  bit          tickMode;

  assign hready = hreadyout;
  itb_irq_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stackFull(stackFull),
    .retiPulse(retiPulse), .svcValid(svcValid), .svcVector(svcVector), .wakeUp(wakeUp),
    .subClkTick(subClkTick), .serialLinkEvt(slEvt), .serialModuleEvt(srcEvt[5]),
    .spiPortEvt(srcEvt[4]), .lowVoltEvt(srcEvt[2]), .eepromWriteEvt(srcEvt[3]),
    .timerMatchA(srcEvt[0]), .timerMatchP(srcEvt[1]));
  itb_core_model core (.core_clk(core_clk), .nrst(nrst), .holdFull(holdFull),
    .retDelay(8'h06), .svcValid(svcValid), .stackFull(stackFull), .retiPulse(retiPulse));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic wrapUp();
    $display("compared %0d mismatches %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fail(input string m);
    $display("MISMATCH %0t %s", $time, m);
    nMismatch++;
  endtask
  task automatic cmpReg(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e) fail($sformatf("reg %h exp %h", g, e));
  endtask
  task automatic cmpVec(input logic [11:0] g, input logic [11:0] e);
    nCompared++;
    if (g !== e) fail($sformatf("vector %h exp %h", g, e));
  endtask
  task automatic cmpNum(input int g, input int e);
    nCompared++;
    if (g != e) fail($sformatf("count %0d exp %0d", g, e));
  endtask

  // sub clock tick every third core cycle
  always @(posedge core_clk) begin
    subCnt     <= (subCnt == 2) ? 0 : subCnt + 1;
    subClkTick <= (subCnt == 2);
  end
  // services checked against expected vector queue
  always @(negedge core_clk) begin
    if (wakeUp === 1'b1) nWake++;
    if (svcValid === 1'b1) begin
      if (vecQ.size() > 0) cmpVec(svcVector, vecQ.pop_front());
      else if (tickMode) cmpVec(svcVector, tickVec);
      else fail("unexpected service");
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 40);
    if (n >= 40) begin fail("bus hang"); wrapUp(); end
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmpReg(rd, e);
  endtask
  task automatic waitWake();
    int w, n;
    w = nWake;
    n = 0;
    while (nWake == w && n < 70000) begin @(posedge core_clk); n++; end
    if (n >= 70000) begin fail("no wake"); wrapUp(); end
  endtask
  task automatic measure(input logic [7:0] off, input logic [31:0] tb,
                         input logic [31:0] psc, input logic [31:0] ctl, input int e);
    int c, w;
    tickMode = 1'b1;
    wr(`ITB_OFF_PSC, psc);
    wr(off, tb);
    wr(`ITB_OFF_CTRL, ctl);
    waitWake();
    w = nWake;
    c = 0;
    while (nWake == w && c < 70000) begin @(posedge core_clk); c++; end
    cmpNum(c, e);
    wr(`ITB_OFF_CTRL, 32'h0);
    wr(off, 32'h0);
    repeat (40) @(posedge core_clk);
    tickMode = 1'b0;
    wr(`ITB_OFF_FLAGS, 32'h0);
  endtask
  task automatic evt(input logic [5:0] s, input logic [5:0] l, input int dw);
    int w;
    w = nWake;
    srcEvt <= s;
    slEvt <= l;
    @(posedge core_clk);
    srcEvt <= 6'h0;
    slEvt <= 6'h0;
    repeat (4) @(posedge core_clk);
    cmpNum(nWake - w, dw);
  endtask

  initial begin
    nrst = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    holdFull = 1'b0; slEvt = 6'h0; srcEvt = 6'h0; seed = 32'h2588; tickMode = 1'b0;
    tickVec = 12'h004; nMismatch = 0; nCompared = 0; nWake = 0; subCnt = 0;
    subClkTick = 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    cmpVec(svcVector, 12'h004);
    for (p = 0; p < 7; p++) rdc(8'(p * 4), 32'h0);
    repeat (4) begin
      d = $random(seed);
      wr(`ITB_OFF_PSC, d);
      rdc(`ITB_OFF_PSC, d & 32'h3);
      wr(`ITB_OFF_TB1, d);
      rdc(`ITB_OFF_TB1, d & 32'h87);
    end
    wr(`ITB_OFF_TB1, 32'h0);
    measure(`ITB_OFF_TB0, 32'h80, 32'h0, 32'h03, 256);
    measure(`ITB_OFF_TB0, 32'h81, 32'h1, 32'h03, 2048);
    measure(`ITB_OFF_TB0, 32'h87, 32'h0, 32'h03, 32768);
    tickVec = 12'h008;
    measure(`ITB_OFF_TB1, 32'h80, 32'h3, 32'h05, 768);
    for (p = 0; p < 6; p++) begin
      evt(6'h0, 6'(1 << p), 1);
      rdc(`ITB_OFF_FLAGS, 32'h4);
      wr(`ITB_OFF_FLAGS, 32'h0);
    end
    wr(`ITB_OFF_SRC, 32'h3f);
    for (p = 0; p < 6; p++) evt(6'(1 << p), 6'h0, 1);
    rdc(`ITB_OFF_SRC, 32'h3f3f);
    rdc(`ITB_OFF_FLAGS, 32'h18);
    evt(6'h01, 6'h0, 0);
    evt(6'h0, 6'h01, 1);
    holdFull <= 1'b1;
    wr(`ITB_OFF_CTRL, 32'h39);
    repeat (20) @(posedge core_clk);
    vecQ = '{12'h00c, 12'h010, 12'h014};
    holdFull <= 1'b0;
    p = 0;
    while (vecQ.size() > 0 && p < 200) begin @(posedge core_clk); p++; end
    cmpNum(vecQ.size(), 0);
    repeat (20) @(posedge core_clk);
    rdc(`ITB_OFF_FLAGS, 32'h0);
    rdc(`ITB_OFF_SRC, 32'h3f3f);
    rdc(`ITB_OFF_CTRL, 32'h39);
    wr(`ITB_OFF_SRC, 32'h0);
    rdc(`ITB_OFF_SRC, 32'h0);
    wrapUp();
  end
endmodule
`default_nettype wire
